/* File: hw/isb_pkg.sv */
// Constants and types of the service data buffer block
// Function
// R1 - start pointer sets first buffer location
// R2 - software clears start pointer before ready
// R3 - in queue writes load buffer bytes
// R4 - queue access only while packet pending
// R5 - in queue burst keeps address fixed
// R6 - out queue burst keeps address fixed
// R7 - not ready answers master reads busy
// R8 - software sets ready after filling queue
// R9 - ready flag releases response to master
// R10 - abort or idle command clears ready
// R11 - out queue returns master data, read-only
// R12 - fill count reports expected out length
// R13 - fill count derived from header bytes
// R14 - pointer loads from start, steps per byte
package isb_pkg;
    localparam logic [7:0] ADDR_START_POINTER = 8'h3F;
    localparam logic [7:0] ADDR_IN_QUEUE = 8'h40;
    localparam logic [7:0] ADDR_READY_CONTROL = 8'h41;
    localparam logic [7:0] ADDR_OUT_QUEUE = 8'h42;
    localparam logic [7:0] ADDR_FILL_COUNT = 8'h43;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int READY_BIT = 0;
    // Header length nibble that defers the length to the second byte
    localparam logic [3:0] LEN_EXTENDED = 4'h1;
    localparam int BUFFER_DEPTH = 256;
    localparam int SKID_DEPTH = 2;

    typedef enum logic [0:0] {
        ISB_TX_IDLE,
        ISB_TX_SEND
    } isb_tx_state_type;
endpackage : isb_pkg

/* File: hw/isb_stream_if.sv */
// Byte stream carrier with valid and ready between internal modules
`timescale 1ns/1ns
interface isb_stream_if #(parameter int WIDTH = 8);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface : isb_stream_if

/* File: hw/isb_skid.sv */
// Small valid/ready buffer that holds words while the receiver stalls
`timescale 1ns/1ns
module isb_skid
    import isb_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = SKID_DEPTH
)(
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset, active high
    isb_stream_if.sink fill, // Filling side
    isb_stream_if.source drain // Draining side
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Refuse depths that the wrapping pointers cannot serve
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_depth_check
        $error("isb_skid: DEPTH must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] slot;
        logic [PW-1:0] rd;
        logic [PW-1:0] wr;
        logic [PW:0] count;
    } isb_skid_state_type;

    isb_skid_state_type state;
    isb_skid_state_type next_state;
    logic push;
    logic pop;

    // Honest full and empty from the entry count
    assign fill.ready = (state.count != (PW + 1)'(DEPTH));
    assign drain.valid = (state.count != '0);
    assign drain.data = state.slot[state.rd];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    // Pointer and count update
    always_comb
    begin
        next_state = state;
        if (push)
        begin
            next_state.slot[state.wr] = fill.data;
            next_state.wr = state.wr + 1'b1;
        end
        if (pop)
            next_state.rd = state.rd + 1'b1;
        if (push && !pop)
            next_state.count = state.count + 1'b1;
        else if (pop && !push)
            next_state.count = state.count - 1'b1;
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (reset)
            state <= '0;
        else
            state <= next_state;
    end
endmodule : isb_skid

/* File: hw/isb_buffer.sv */
// Service data buffer with software queues and response streaming
`timescale 1ns/1ns
module isb_buffer
    import isb_pkg::*;
#(
    parameter int DEPTH = BUFFER_DEPTH
)(
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic [7:0] reg_addr, // Register address from serial port
    input wire logic reg_write, // Register write strobe
    input wire logic reg_read, // Register read strobe
    input wire logic [7:0] reg_wdata, // Register write data
    output logic [7:0] reg_rdata, // Register read data
    output logic reg_rvalid, // Read data valid pulse
    output logic addr_hold, // Serial port must not step the address
    input wire logic packet_pending_flag, // Buffer owned by software
    input wire logic new_write_start_flag, // Master began a new write
    input wire logic master_byte_valid, // Out transfer byte from master
    input wire logic [7:0] master_byte, // Out transfer byte value
    input wire logic master_out_end, // Out transfer finished pulse
    input wire logic master_read_req, // Master asks for response
    input wire logic master_abort, // Abort or idle command pulse
    output logic busy_reply, // Answer busy pulse
    output logic response_ready_flag, // Response released flag
    output logic tx_valid, // Response byte valid
    input wire logic tx_ready, // Link accepts response byte
    output logic [7:0] tx_data // Response byte
);
    // Refuse depths that the 8-bit pointers cannot address
    if (DEPTH != 256)
    begin : g_depth_check
        $error("isb_buffer: DEPTH must be 256 for an 8-bit pointer");
    end

    // All control state of the block in one register
    typedef struct packed {
        logic [7:0] start_pointer;
        logic [7:0] pointer;
        logic [7:0] in_length;
        logic [7:0] fill_count;
        logic ready;
        logic [7:0] rdata;
        logic rvalid;
        logic busy;
        isb_tx_state_type tx_state;
        logic [7:0] tx_ptr;
        logic hdr_pending;
    } isb_state_type;

    // State, buffer storage and queue strobes
    isb_state_type state;
    isb_state_type next_state;
    logic [7:0] mem [DEPTH];
    logic access_ok;
    logic in_write;
    logic out_read;
    logic load_push;
    logic [7:0] header_len;

    // Decoded register writes and master requests
    logic start_write;
    logic ready_write;
    logic busy_now;
    logic send_start;
    logic send_done;

    // Streams into and out of the two-entry buffer
    isb_stream_if #(.WIDTH(8)) load_if ();
    isb_stream_if #(.WIDTH(8)) link_if ();

    // Length from header: low nibble, or the second byte when extended
    function automatic logic [7:0] header_length(input logic [7:0] b0, input logic [7:0] b1);
        if (b0[3:0] == LEN_EXTENDED)
            return b1;
        return {4'h0, b0[3:0]};
    endfunction : header_length

    // Match of the register address against one offset
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
        return a == target;
    endfunction : addr_hit

    // One step of an 8-bit buffer pointer, wrapping past the top
    function automatic logic [7:0] ptr_step(input logic [7:0] p);
        return p + 8'h01;
    endfunction : ptr_step

    // Queue strobes, gated by buffer ownership; the address hold is not gated
    assign access_ok = packet_pending_flag; // R4
    assign in_write = reg_write && addr_hit(reg_addr, ADDR_IN_QUEUE) && access_ok; // R3
    assign out_read = reg_read && addr_hit(reg_addr, ADDR_OUT_QUEUE) && access_ok; // R11
    assign addr_hold = addr_hit(reg_addr, ADDR_IN_QUEUE) // R5
        || addr_hit(reg_addr, ADDR_OUT_QUEUE); // R6
    assign header_len = header_length(mem[0], mem[1]); // R13

    // Register strobes that leave the buffer alone
    assign start_write = reg_write && addr_hit(reg_addr, ADDR_START_POINTER); // R1
    assign ready_write = reg_write && addr_hit(reg_addr, ADDR_READY_CONTROL); // R8

    // Master requests: busy while not released, else start sending from idle
    assign busy_now = master_read_req && !state.ready; // R7
    assign send_start = master_read_req && state.ready && state.tx_state == ISB_TX_IDLE; // R9
    assign send_done = master_abort || !load_if.valid; // R10

    // Feed response bytes into the buffer while it has room
    assign load_if.valid = state.tx_state == ISB_TX_SEND && state.tx_ptr != state.in_length;
    assign load_if.data = mem[state.tx_ptr];
    assign load_push = load_if.valid && load_if.ready;
    assign tx_valid = link_if.valid;
    assign tx_data = link_if.data;
    assign link_if.ready = tx_ready;

    // Two-entry buffer so that a stalled link loses no response byte
    isb_skid #(.WIDTH(8), .DEPTH(SKID_DEPTH)) u_skid (
        .clk(clk),
        .reset(reset),
        .fill(load_if.sink),
        .drain(link_if.source)
    );

    // Register, pointer and response sequencing
    always_comb
    begin
        next_state = state;
        next_state.rvalid = 1'b0;
        next_state.busy = 1'b0;
        // Start pointer write reloads the working pointer
        if (start_write)
        begin
            next_state.start_pointer = reg_wdata; // R1
            next_state.pointer = reg_wdata; // R14
        end
        // Queue accesses step the working pointer; the register address stays put
        if (in_write)
        begin
            next_state.pointer = ptr_step(state.pointer); // R14
            next_state.in_length = ptr_step(state.pointer);
        end
        if (out_read)
            next_state.pointer = ptr_step(state.pointer); // R14
        // Read data is registered and stands until the next read
        if (reg_read)
        begin
            next_state.rvalid = 1'b1;
            unique case (reg_addr)
                ADDR_START_POINTER: next_state.rdata = state.start_pointer;
                ADDR_READY_CONTROL: next_state.rdata = {7'h00, state.ready};
                ADDR_OUT_QUEUE: next_state.rdata = access_ok ? mem[state.pointer] : RESET_BYTE;
                ADDR_FILL_COUNT: next_state.rdata = state.fill_count; // R12
                default: next_state.rdata = RESET_BYTE;
            endcase
        end
        // Fill count follows the header one cycle after the out transfer ends;
        // a new end pulse in that same cycle re-arms the update
        if (state.hdr_pending)
        begin
            next_state.hdr_pending = 1'b0;
            next_state.fill_count = header_len; // R12 R13
        end
        if (master_out_end)
            next_state.hdr_pending = 1'b1;
        // Abort clears ready; a software set in the same cycle wins
        if (master_abort)
            next_state.ready = 1'b0; // R10
        if (ready_write)
            next_state.ready = reg_wdata[READY_BIT]; // R8
        // Any request while not released gets a busy answer, even mid-send
        if (busy_now)
            next_state.busy = 1'b1; // R7
        unique case (state.tx_state)
            ISB_TX_IDLE:
            begin
                if (send_start)
                begin
                    next_state.tx_state = ISB_TX_SEND; // R9
                    next_state.tx_ptr = 8'h00;
                end
            end
            ISB_TX_SEND:
            begin
                // Stream the loaded response bytes in order
                if (load_push)
                    next_state.tx_ptr = ptr_step(state.tx_ptr); // R9
                if (send_done)
                    next_state.tx_state = ISB_TX_IDLE; // R10
            end
        endcase
    end

    // State register
    // Buffer memory is left alone by reset, only the control state clears
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= '0;
            state.start_pointer <= RESET_BYTE;
            state.fill_count <= RESET_BYTE;
            state.tx_state <= ISB_TX_IDLE;
        end
        else
            state <= next_state;
    end

    // Buffer storage: software and master bytes both at the working pointer, software first
    always_ff @(posedge clk)
    begin
        if (in_write)
            mem[state.pointer] <= reg_wdata; // R3 R5
        else if (master_byte_valid)
            mem[state.pointer] <= master_byte; // R11
    end

    // Outputs straight from the state register
    assign reg_rdata = state.rdata;
    assign reg_rvalid = state.rvalid;
    assign busy_reply = state.busy;
    assign response_ready_flag = state.ready;

    // Master bytes are stored whether or not software owns the buffer; new write start is unused
    logic unused_flags;
    assign unused_flags = new_write_start_flag;
endmodule : isb_buffer

/* File: verification/isb_buffer_asserts.sv */
// Port checker for the service data buffer
`timescale 1ns/1ns
module isb_buffer_asserts
    import isb_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic reset, // Reset
    input wire logic [7:0] reg_addr, // Address
    input wire logic reg_write, // Write strobe
    input wire logic reg_read, // Read strobe
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic reg_rvalid, // Read valid
    input wire logic addr_hold, // Burst hold
    input wire logic packet_pending_flag, // Owner flag
    input wire logic master_read_req, // Request
    input wire logic master_abort, // Abort
    input wire logic busy_reply, // Busy
    input wire logic response_ready_flag, // Ready
    input wire logic tx_valid, // Byte valid
    input wire logic tx_ready, // Byte taken
    input wire logic [7:0] tx_data // Byte
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // Register bus and link relations
    a_read_answers: assert property (reg_read |=> reg_rvalid)
        else $error("read not answered");
    a_hold_queue: assert property (addr_hold == (reg_addr == ADDR_IN_QUEUE ||
        reg_addr == ADDR_OUT_QUEUE)) else $error("address hold wrong");
    a_busy_reply: assert property (master_read_req && !response_ready_flag |=> busy_reply)
        else $error("busy missing");
    a_busy_cause: assert property (busy_reply |->
        $past(master_read_req) && !$past(response_ready_flag)) else $error("busy stray");
    a_abort_clears: assert property (master_abort &&
        !(reg_write && reg_addr == ADDR_READY_CONTROL) |=> !response_ready_flag)
        else $error("abort kept ready");
    a_ready_write: assert property (reg_write && reg_addr == ADDR_READY_CONTROL |=>
        {7'h00, response_ready_flag} == ($past(reg_wdata) & 8'h01)) else $error("ready bad");
    a_refused_read: assert property (reg_read && reg_addr == ADDR_OUT_QUEUE &&
        !packet_pending_flag |=> reg_rdata == RESET_BYTE) else $error("refused read data");
    a_tx_stands: assert property (tx_valid && !tx_ready && !master_abort |=>
        tx_valid && $stable(tx_data)) else $error("byte dropped");
endmodule : isb_buffer_asserts

bind isb_buffer isb_buffer_asserts u_chk (.clk, .reset, .reg_addr, .reg_write, .reg_read,
    .reg_wdata, .reg_rdata, .reg_rvalid, .addr_hold, .packet_pending_flag, .master_read_req,
    .master_abort, .busy_reply, .response_ready_flag, .tx_valid, .tx_ready, .tx_data);

/* File: verification/isb_master_model.sv */
// Link master model: requests, out bytes and response capture
`timescale 1ns/1ns
module isb_master_model (
    input wire logic clk, // Clock
    input wire logic tx_valid, // Response valid
    input wire logic [7:0] tx_data, // Response byte
    input wire logic busy_reply, // Busy answer
    output logic master_byte_valid, // Out byte strobe
    output logic [7:0] master_byte, // Out byte
    output logic master_out_end, // Out end pulse
    output logic master_read_req, // Request pulse
    output logic master_abort, // Abort pulse
    output logic tx_ready // Takes response byte
);
    logic slow = 1'b0;
    logic [2:0] tick = 3'h0;
    int busy_cnt = 0;
    logic [7:0] rx_q[$];
    initial {master_byte_valid, master_byte, master_out_end, master_read_req, master_abort} = '0;
    // Stall pattern when slow
    assign tx_ready = !slow || tick[1];
    always @(negedge clk) tick <= tick + 3'h1;
    // Capture response bytes and busy answers
    always @(posedge clk)
    begin
        if (tx_valid && tx_ready)
            rx_q.push_back(tx_data);
        if (busy_reply)
            busy_cnt++;
    end
    // One-cycle command: 0 request, 1 abort, 2 out byte, 3 out end
    task automatic pulse(input int kind, input logic [7:0] b);
        @(negedge clk);
        master_read_req = (kind == 0);
        master_abort = (kind == 1);
        master_byte_valid = (kind == 2);
        master_byte = b;
        master_out_end = (kind == 3);
        @(negedge clk);
        {master_read_req, master_abort, master_byte_valid, master_out_end} = '0;
        master_byte = ~b;
    endtask : pulse
endmodule : isb_master_model

/* File: verification/isb_buffer_tb_top.sv */
// Testbench for the service data buffer
`timescale 1ns/1ns
module isb_buffer_tb_top import isb_pkg::*;;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic packet_pending_flag = 1'b0;
    logic new_write_start_flag = 1'b0;
    logic [7:0] reg_rdata, master_byte, tx_data;
    logic reg_rvalid, addr_hold, master_byte_valid, master_out_end, master_read_req;
    logic master_abort, busy_reply, response_ready_flag, tx_valid, tx_ready;
    logic [7:0] hdr [4] = '{8'h73, 8'h55, 8'h41, 8'h09};
    logic [7:0] lvl [2] = '{8'h03, 8'h09};
    int error_cnt = 0;
    int comparisons = 0;
    isb_buffer uut (.clk, .reset, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata,
        .reg_rvalid, .addr_hold, .packet_pending_flag, .new_write_start_flag,
        .master_byte_valid, .master_byte, .master_out_end, .master_read_req, .master_abort,
        .busy_reply, .response_ready_flag, .tx_valid, .tx_ready, .tx_data);
    isb_master_model link (.clk, .tx_valid, .tx_data, .busy_reply, .master_byte_valid,
        .master_byte, .master_out_end, .master_read_req, .master_abort, .tx_ready);
    // Clock of 4 ns
    initial forever #2 clk = ~clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clk);
        reg_read = 1'b0;
        chk({7'h00, reg_rvalid}, 8'h01);
        chk(reg_rdata, exp);
    endtask : rd
    task automatic wrap_up;
        $display("TB: %0d compares, %0d errors", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // Watchdog
    initial
    begin
        #40000;
        error_cnt++;
        wrap_up();
    end
    // Test sequence
    initial
    begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        for (int a = 'h3F; a <= 'h43; a++)
            rd(a[7:0], 8'h00);
        rd(8'h50, 8'h00);
        $display("TB: reset values done");
        packet_pending_flag = 1'b1;
        wr(ADDR_START_POINTER, 8'h00);
        for (int i = 0; i < 4; i++)
            wr(ADDR_IN_QUEUE, 8'hA0 + i[7:0]);
        chk({7'h00, addr_hold}, 8'h01);
        packet_pending_flag = 1'b0;
        wr(ADDR_IN_QUEUE, 8'hFF);
        packet_pending_flag = 1'b1;
        wr(ADDR_IN_QUEUE, 8'hA4);
        packet_pending_flag = 1'b0;
        link.pulse(0, 8'h00);
        wr(ADDR_READY_CONTROL, 8'h01);
        chk(8'(link.busy_cnt), 8'h01);
        rd(ADDR_READY_CONTROL, 8'h01);
        link.slow = 1'b1;
        link.pulse(0, 8'h00);
        for (int i = 0; i < 300 && link.rx_q.size() < 5; i++)
            @(negedge clk);
        chk(8'(link.rx_q.size()), 8'h05);
        for (int i = 0; i < 5; i++)
            chk(link.rx_q[i], 8'hA0 + i[7:0]);
        link.pulse(1, 8'h00);
        rd(ADDR_READY_CONTROL, 8'h00);
        link.pulse(0, 8'h00);
        @(negedge clk);
        chk(8'(link.busy_cnt), 8'h02);
        $display("TB: response test done");
        for (int t = 0; t < 2; t++)
        begin
            packet_pending_flag = 1'b0;
            for (int i = 0; i < 2; i++)
            begin
                wr(ADDR_START_POINTER, i[7:0]);
                link.pulse(2, hdr[2*t+i]);
            end
            link.pulse(3, 8'h00);
            repeat (2) @(negedge clk);
            rd(ADDR_FILL_COUNT, lvl[t]);
            packet_pending_flag = 1'b1;
            wr(ADDR_START_POINTER, 8'h00);
            rd(ADDR_OUT_QUEUE, hdr[2*t]);
            rd(ADDR_OUT_QUEUE, hdr[2*t+1]);
            chk({7'h00, addr_hold}, 8'h01);
        end
        wr(ADDR_START_POINTER, 8'h01);
        rd(ADDR_START_POINTER, 8'h01);
        rd(ADDR_OUT_QUEUE, hdr[3]);
        wr(ADDR_FILL_COUNT, 8'hEE);
        rd(ADDR_FILL_COUNT, 8'h09);
        chk({7'h00, addr_hold}, 8'h00);
        $display("TB: out transfer test done");
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        rd(ADDR_START_POINTER, 8'h00);
        rd(ADDR_FILL_COUNT, 8'h00);
        chk({7'h00, tx_valid}, 8'h00);
        $display("TB: mid-run reset test done");
        wrap_up();
    end
endmodule : isb_buffer_tb_top
